/* hdl/occ_pkg.sv */
// Purpose: Shared constants and types for the output compare channel array.
// Assumes: Word-addressed register port, 16-bit data, one clock domain.
// Notes:   Channel c owns register indices c*4+0 .. c*4+2.
package occ_pkg;

   // ****************************************************************
   // Geometry
   // ****************************************************************
   localparam int OCC_NUM_CH = 8;
   localparam int OCC_FAULT_A_LAST = 3;
   localparam int OCC_DATA_W = 16;
   localparam int OCC_ADDR_W = 5;
   localparam int OCC_MODE_W = 3;

   // ****************************************************************
   // Register map (index within a channel's block of four)
   // ****************************************************************
   localparam logic [1:0] OCC_REG_CONTROL = 2'h0;
   localparam logic [1:0] OCC_REG_PRIMARY = 2'h1;
   localparam logic [1:0] OCC_REG_SECONDARY = 2'h2;

   // Control field positions
   localparam int OCC_BIT_MODE_LO = 0;
   localparam int OCC_BIT_TSEL = 3;
   localparam int OCC_BIT_FAULT = 4;
   localparam int OCC_BIT_SIDL = 13;

   localparam logic [15:0] OCC_CTRL_RESET = 16'h0000;
   localparam logic [15:0] OCC_VALUE_RESET = 16'h0000;
   localparam logic [15:0] OCC_READ_UNMAPPED = 16'h0000;

   // ****************************************************************
   // Mode encodings
   // ****************************************************************
   localparam logic [2:0] OCC_MODE_OFF = 3'h0;
   localparam logic [2:0] OCC_MODE_HIGH = 3'h1;
   localparam logic [2:0] OCC_MODE_LOW = 3'h2;
   localparam logic [2:0] OCC_MODE_TOGGLE = 3'h3;
   localparam logic [2:0] OCC_MODE_ONE_PULSE = 3'h4;
   localparam logic [2:0] OCC_MODE_PULSES = 3'h5;
   localparam logic [2:0] OCC_MODE_PWM = 3'h6;
   localparam logic [2:0] OCC_MODE_PWM_FAULT = 3'h7;

   // ****************************************************************
   // Timing, in instruction clocks
   // ****************************************************************
   localparam int OCC_MATCH_TO_PIN_CYC = 1;
   localparam int OCC_PIN_TO_FLAG_CYC = 2;

   // ****************************************************************
   // Types
   // ****************************************************************
   typedef struct packed {
      logic idle_halt_select;
      logic fault_seen_flag;
      logic time_base_select;
      logic [2:0] compare_mode_field;
   } occ_ctrl_s;

   typedef struct packed {
      logic [15:0] count;
      logic [15:0] period;
   } occ_time_base_s;

   typedef enum logic [1:0] {
      OCC_PH_LEAD,
      OCC_PH_TRAIL,
      OCC_PH_DONE
   } occ_phase_e;

   function automatic logic [15:0] occ_ctrl_word(input occ_ctrl_s c);
      logic [15:0] w;
      w = 16'h0000;
      w[OCC_BIT_SIDL] = c.idle_halt_select;
      w[OCC_BIT_FAULT] = c.fault_seen_flag;
      w[OCC_BIT_TSEL] = c.time_base_select;
      w[OCC_BIT_MODE_LO +: OCC_MODE_W] = c.compare_mode_field;
      return w;
   endfunction

endpackage

/* hdl/occ_sync2.sv */
// Purpose: Two-flop synchroniser for asynchronous pin inputs.
// Assumes: Input bits are independent levels.
// Notes:   The first stage feeds only the second stage.
`timescale 1ns/1ps
`default_nettype none

module occ_sync2 #(
   parameter int WIDTH = 1
) (
   input wire logic ref_clk,
   input wire logic rst_b,
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);

   logic [WIDTH-1:0] stage1;

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         stage1 <= '0;
         sync_out <= '0;
      end else begin
         stage1 <= async_in;
         sync_out <= stage1;
      end
   end

endmodule

`default_nettype wire

/* hdl/occ_top.sv */
// Purpose: Array of identical output compare channels with a register port.
// Assumes: Time bases and idle come from logic on ref_clk; fault pins are async.
// Notes:   Register read data appear in the cycle after the read strobe.
`timescale 1ns/1ps
`default_nettype none

module occ_top
   import occ_pkg::*;
(
   input wire logic ref_clk,
   input wire logic rst_b,
   input wire logic [OCC_ADDR_W-1:0] reg_addr,
   input wire logic [OCC_DATA_W-1:0] reg_wdata,
   input wire logic reg_write,
   input wire logic reg_read,
   output logic [OCC_DATA_W-1:0] reg_rdata,
   input wire occ_time_base_s time_base_first,
   input wire occ_time_base_s time_base_second,
   input wire logic cpu_idle,
   input wire logic fault_input_a,
   input wire logic fault_input_b,
   output logic [OCC_NUM_CH-1:0] compare_output_pin,
   output logic [OCC_NUM_CH-1:0] compare_event_flag
);

   // ****************************************************************
   // Fault pin synchronisation
   // ****************************************************************
   // A fault pulse shorter than one clock may be missed by the sync
   logic [1:0] fault_sync;

   occ_sync2 #(
      .WIDTH(2)
   ) u_fault_sync (
      .ref_clk(ref_clk),
      .rst_b(rst_b),
      .async_in({fault_input_b, fault_input_a}),
      .sync_out(fault_sync)
   );

   // ****************************************************************
   // Register port decode
   // ****************************************************************
   wire [2:0] sel_ch = reg_addr[4:2];
   wire [1:0] sel_reg = reg_addr[1:0];
   wire wr_control = reg_write && (sel_reg == OCC_REG_CONTROL);
   wire wr_primary = reg_write && (sel_reg == OCC_REG_PRIMARY);
   wire wr_secondary = reg_write && (sel_reg == OCC_REG_SECONDARY);

   occ_ctrl_s ctrl [OCC_NUM_CH];
   logic [15:0] primary_compare_value [OCC_NUM_CH];
   logic [15:0] secondary_compare_value [OCC_NUM_CH];
   logic [15:0] ctrl_word [OCC_NUM_CH];

   // Index 3 of each channel block reads zero and ignores writes
   wire [15:0] rd_mux =
      (sel_reg == OCC_REG_CONTROL) ? ctrl_word[sel_ch] :
      (sel_reg == OCC_REG_PRIMARY) ? primary_compare_value[sel_ch] :
      (sel_reg == OCC_REG_SECONDARY) ? secondary_compare_value[sel_ch] :
      OCC_READ_UNMAPPED;

   // Read data stand for one clock only, then fall back to zero
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         reg_rdata <= OCC_VALUE_RESET;
      end else if (reg_read) begin
         reg_rdata <= rd_mux;
      end else begin
         reg_rdata <= OCC_READ_UNMAPPED;
      end
   end

   // ****************************************************************
   // Channels
   // ****************************************************************
   genvar ch;
   generate
      for (ch = 0; ch < OCC_NUM_CH; ch++) begin : g_ch
         // ****************************************************************
         // Register writes
         // ****************************************************************
         // Per-channel write strobes
         wire hit = (sel_ch == 3'(ch));
         wire wr_c = wr_control && hit;
         wire wr_p = wr_primary && hit;
         wire wr_s = wr_secondary && hit;

         // Only the mode, time base and idle bits are writable
         wire [2:0] new_mode = reg_wdata[OCC_BIT_MODE_LO +: OCC_MODE_W];
         wire new_tsel = reg_wdata[OCC_BIT_TSEL];
         wire new_sidl = reg_wdata[OCC_BIT_SIDL];

         wire [2:0] mode = ctrl[ch].compare_mode_field;

         // ****************************************************************
         // Compare sources
         // ****************************************************************
         // Fault pin grouping
         // Channels 0 to 3 answer fault A, 4 to 7 fault B
         wire fault_in = (ch <= OCC_FAULT_A_LAST) ? fault_sync[0] : fault_sync[1];

         // Selected time base
         wire [15:0] count = ctrl[ch].time_base_select ?
                             time_base_second.count : time_base_first.count;
         wire [15:0] period = ctrl[ch].time_base_select ?
                              time_base_second.period : time_base_first.period;

         // Idle halt freezes channel state; the fault status and the event pipeline keep running
         // Halt stops the pin, phase and match history alike, so leaving
         // idle resumes exactly where the channel stopped
         wire halted = ctrl[ch].idle_halt_select && cpu_idle;
         wire active = (mode != OCC_MODE_OFF) && !halted;

         // ****************************************************************
         // Match detection
         // ****************************************************************
         // Exact equality, acted on only at its first cycle except by the PWM duty match, so a stopped
         // timer parked on the compare value cannot fire again and again
         wire eq_p = (count == primary_compare_value[ch]);
         wire eq_s = (count == secondary_compare_value[ch]);
         wire eq_per = (count == period);
         logic eq_p_d;
         logic eq_s_d;
         logic eq_per_d;
         wire match_p = eq_p && !eq_p_d;
         wire match_s = eq_s && !eq_s_d;
         wire match_per = eq_per && !eq_per_d;

         // Mode entry seen as a change from the last mode value
         // A rewrite of the same mode is not an entry; software clears the
         // mode field first when it wants the start level applied again
         logic [2:0] prev_mode;
         wire entry = (mode != prev_mode);

         // ****************************************************************
         // Channel state
         // ****************************************************************
         logic pin;
         occ_phase_e phase;
         logic [15:0] duty;
         logic [OCC_PIN_TO_FLAG_CYC:0] evt_pipe;
         logic fault_flag;

         wire pwm_mode = (mode == OCC_MODE_PWM) || (mode == OCC_MODE_PWM_FAULT);
         wire fault_on = (mode == OCC_MODE_PWM_FAULT) && fault_in;

         // ****************************************************************
         // Next pin and event
         // ****************************************************************
         // Next pin value and compare event, before the pin register
         // Disable beats entry, and entry beats a match in the same cycle
         logic next_pin;
         occ_phase_e next_phase;
         logic next_evt;

         always_comb begin
            next_pin = pin;
            next_phase = phase;
            next_evt = 1'b0;
            if (mode == OCC_MODE_OFF) begin
               next_pin = 1'b0;
               next_phase = OCC_PH_LEAD;
            end else if (entry) begin
               next_phase = OCC_PH_LEAD;
               case (mode)
                  OCC_MODE_HIGH: next_pin = 1'b0;
                  OCC_MODE_LOW: next_pin = 1'b1;
                  // Toggle keeps the level left by the previous mode
                  OCC_MODE_TOGGLE: next_pin = pin;
                  OCC_MODE_ONE_PULSE: next_pin = 1'b0;
                  OCC_MODE_PULSES: next_pin = 1'b0;
                  default: next_pin = 1'b0;
               endcase
            end else if (active) begin
               case (mode)
                  OCC_MODE_HIGH: begin
                     if (match_p && phase == OCC_PH_LEAD) begin
                        next_pin = 1'b1;
                        next_phase = OCC_PH_DONE;
                        next_evt = 1'b1;
                     end
                  end
                  OCC_MODE_LOW: begin
                     if (match_p && phase == OCC_PH_LEAD) begin
                        next_pin = 1'b0;
                        next_phase = OCC_PH_DONE;
                        next_evt = 1'b1;
                     end
                  end
                  OCC_MODE_TOGGLE: begin
                     if (match_p) begin
                        next_pin = !pin;
                        next_evt = 1'b1;
                     end
                  end
                  OCC_MODE_ONE_PULSE, OCC_MODE_PULSES: begin
                     if (phase == OCC_PH_LEAD && match_p) begin
                        next_pin = 1'b1;
                        next_phase = OCC_PH_TRAIL;
                     end else if (phase == OCC_PH_TRAIL && match_s) begin
                        next_pin = 1'b0;
                        next_evt = 1'b1;
                        // One pulse stops here; continuous rearms
                        next_phase = (mode == OCC_MODE_ONE_PULSE) ?
                                     OCC_PH_DONE : OCC_PH_LEAD;
                     end
                  end
                  default: begin
                     // PWM: high from period rollover, low at duty match
                     // Duty is latched at rollover, so a mid-period write waits
                     if (fault_on) begin
                        next_pin = 1'b0;
                     end else if (match_per) begin
                        next_pin = (secondary_compare_value[ch] != OCC_VALUE_RESET);
                     end else if (eq_p && (duty == primary_compare_value[ch])) begin
                        next_pin = 1'b0;
                     end
                  end
               endcase
            end
         end

         // ****************************************************************
         // Registers
         // ****************************************************************
         // Control and compare registers
         always_ff @(posedge ref_clk or negedge rst_b) begin
            if (!rst_b) begin
               ctrl[ch] <= occ_ctrl_s'(6'h00);
               primary_compare_value[ch] <= OCC_VALUE_RESET;
               secondary_compare_value[ch] <= OCC_VALUE_RESET;
            end else begin
               if (wr_c) begin
                  ctrl[ch].compare_mode_field <= new_mode;
                  ctrl[ch].time_base_select <= new_tsel;
                  ctrl[ch].idle_halt_select <= new_sidl;
               end
               // PWM takes the new duty from the secondary value each period
               if (wr_p) begin
                  primary_compare_value[ch] <= reg_wdata;
               end else if (pwm_mode && active && match_per) begin
                  primary_compare_value[ch] <= secondary_compare_value[ch];
               end
               if (wr_s) begin
                  secondary_compare_value[ch] <= reg_wdata;
               end
               ctrl[ch].fault_seen_flag <= fault_flag;
            end
         end

         // ****************************************************************
         // Fault status
         // ****************************************************************
         // Set wins over clear when both fall in one clock
         // Fault status: set while fault pin active, cleared by hardware once
         // the pin is quiet at a period rollover or the mode leaves 111
         always_ff @(posedge ref_clk or negedge rst_b) begin
            if (!rst_b) begin
               fault_flag <= 1'b0;
            end else if (fault_on) begin
               fault_flag <= 1'b1;
            end else if (mode != OCC_MODE_PWM_FAULT || (match_per && !fault_in)) begin
               fault_flag <= 1'b0;
            end
         end

         // ****************************************************************
         // Pin and history
         // ****************************************************************
         // Pin, phase and match history
         always_ff @(posedge ref_clk or negedge rst_b) begin
            if (!rst_b) begin
               pin <= 1'b0;
               phase <= OCC_PH_LEAD;
               prev_mode <= OCC_MODE_OFF;
               eq_p_d <= 1'b0;
               eq_s_d <= 1'b0;
               eq_per_d <= 1'b0;
               duty <= OCC_VALUE_RESET;
            end else if (!halted) begin
               pin <= next_pin;
               phase <= next_phase;
               prev_mode <= mode;
               eq_p_d <= eq_p;
               eq_s_d <= eq_s;
               eq_per_d <= eq_per;
               if (match_per) begin
                  duty <= secondary_compare_value[ch];
               end
            end
         end

         // ****************************************************************
         // Event pipeline
         // ****************************************************************
         // Events are one-clock pulses; the interrupt logic outside latches them
         // Event pipeline: stage 0 lines up with the pin change, the
         // flag leaves after the stated extra delay
         always_ff @(posedge ref_clk or negedge rst_b) begin
            if (!rst_b) begin
               evt_pipe <= '0;
            end else begin
               evt_pipe <= {evt_pipe[OCC_PIN_TO_FLAG_CYC-1:0], next_evt && !halted};
            end
         end

         // ****************************************************************
         // Outputs
         // ****************************************************************
         assign compare_output_pin[ch] = pin;
         assign compare_event_flag[ch] = evt_pipe[OCC_PIN_TO_FLAG_CYC];
         assign ctrl_word[ch] = occ_ctrl_word(ctrl[ch]);
      end
   endgenerate

endmodule

`default_nettype wire

/* test/occ_timer_model.sv */
// Purpose: Time base model feeding count and period to the channels.
// Assumes: Runs on ref_clk; run low parks the count at zero.
// Notes:   Parking at zero gives each scenario a known match phase.
`timescale 1ns/1ps
`default_nettype none

module occ_timer_model
   import occ_pkg::*;
#(
   parameter logic [15:0] PERIOD = 16'h0013
) (
   input wire logic ref_clk,
   input wire logic rst_b,
   input wire logic run,
   output wire occ_time_base_s tb_out
);
   logic [15:0] cnt;

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         cnt <= 16'h0000;
      end else if (!run) begin
         cnt <= 16'h0000;
      end else if (cnt == PERIOD) begin
         cnt <= 16'h0000;
      end else begin
         cnt <= cnt + 16'h0001;
      end
   end

   assign tb_out = {cnt, PERIOD};
endmodule

`default_nettype wire

/* test/occ_top_asserts.sv */
// Purpose: Port-level timing checks of the compare channel array.
// Assumes: Channel 0 state is mirrored from the register port writes.
// Notes:   Match timing is checked on channel 0 only, to keep the checker small.
`timescale 1ns/1ps
`default_nettype none

module occ_top_asserts
   import occ_pkg::*;
(
   input wire logic ref_clk,
   input wire logic rst_b,
   input wire logic [OCC_ADDR_W-1:0] reg_addr,
   input wire logic [OCC_DATA_W-1:0] reg_wdata,
   input wire logic reg_write,
   input wire logic reg_read,
   input wire logic [OCC_DATA_W-1:0] reg_rdata,
   input wire occ_time_base_s time_base_first,
   input wire occ_time_base_s time_base_second,
   input wire logic cpu_idle,
   input wire logic fault_input_a,
   input wire logic fault_input_b,
   input wire logic [OCC_NUM_CH-1:0] compare_output_pin,
   input wire logic [OCC_NUM_CH-1:0] compare_event_flag
);
   // ****************************************************************
   // Mirror of channel 0
   // ****************************************************************
   logic [2:0] m0;
   logic t0;
   logic s0;
   logic [15:0] p0;
   wire [15:0] cnt = t0 ? time_base_second.count : time_base_first.count;
   wire halt = s0 && cpu_idle;
   wire pin = compare_output_pin[0];
   wire flag = compare_event_flag[0];

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         m0 <= 3'h0;
         t0 <= 1'h0;
         s0 <= 1'h0;
         p0 <= 16'h0000;
      end else if (reg_write && reg_addr == 5'h00) begin
         m0 <= reg_wdata[2:0];
         t0 <= reg_wdata[3];
         s0 <= reg_wdata[13];
      end else if (reg_write && reg_addr == 5'h01) begin
         p0 <= reg_wdata;
      end
   end

   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rst_b);

   // ****************************************************************
   // Properties
   // ****************************************************************
   a_unused_zero: assert property ($past(reg_read) && $past(reg_addr[1:0]) == 2'h0
      |-> reg_rdata[15:14] == 2'h0 && reg_rdata[12:5] == 8'h00)
      else $error("unimplemented control bits read nonzero");
   a_ctrl_readback: assert property ($past(reg_read) && $past(reg_addr) == 5'h00
      |-> reg_rdata[2:0] == m0 && reg_rdata[3] == t0 && reg_rdata[13] == s0)
      else $error("control readback differs from last write");
   a_off_pin: assert property (m0 == OCC_MODE_OFF && $past(m0) == OCC_MODE_OFF |-> !pin)
      else $error("disabled channel drives pin");
   a_off_quiet: assert property (m0 == 3'h0 && $past(m0) == 3'h0 && $past(m0, 2) == 3'h0
      && $past(m0, 3) == 3'h0 |-> !flag)
      else $error("disabled channel raised event");
   a_high_rise: assert property (m0 == OCC_MODE_HIGH && $past(m0) == OCC_MODE_HIGH
      && !halt && cnt == p0 && $past(cnt) != p0 && $stable(p0) |=> pin)
      else $error("pin not high one clock after match");
   a_high_hold: assert property ((m0 == OCC_MODE_HIGH && pin) ##1 m0 == OCC_MODE_HIGH
      |-> pin)
      else $error("pin left high state without mode change");
   a_high_flag: assert property ($rose(pin) && m0 == OCC_MODE_HIGH
      && $past(m0) == OCC_MODE_HIGH && !halt |-> ##2 flag)
      else $error("event not two clocks after rise");
   a_low_flag: assert property ($fell(pin) && m0 == OCC_MODE_LOW
      && $past(m0) == OCC_MODE_LOW && !halt |-> ##2 flag)
      else $error("event not two clocks after fall");
   a_flag_cause: assert property (flag |-> $past(pin, 2) != $past(pin, 3))
      else $error("event without pin change two clocks before");
   a_idle_freeze: assert property (halt && $past(halt) |-> $stable(pin))
      else $error("pin moved while halted in idle");
endmodule

bind occ_top occ_top_asserts u_chk (.ref_clk(ref_clk), .rst_b(rst_b), .reg_addr(reg_addr),
   .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
   .time_base_first(time_base_first), .time_base_second(time_base_second),
   .cpu_idle(cpu_idle), .fault_input_a(fault_input_a), .fault_input_b(fault_input_b),
   .compare_output_pin(compare_output_pin), .compare_event_flag(compare_event_flag));

`default_nettype wire

/* test/tb.sv */
// Purpose: Self-checking bench for the compare channel array.
// Assumes: Channel 0 compares against 16'h0010 and 16'h0012.
// Notes:   Second base wraps at 16'h0013; first at 16'h000F never matches.
`timescale 1ns/1ps
`default_nettype none

`define OCC_CHK(what, exp, got) begin compares++; if ((got) !== (exp)) begin miscompares++; \
   $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got); end end

module tb;
   import occ_pkg::*;
   typedef struct packed {
      logic [2:0] mode;
      logic tsel;
      logic sidl;
      logic idle;
      logic entry;
      logic final_pin;
      logic [1:0] flags;
   } occ_row_s;

   logic ref_clk = 1'h0;
   logic rst_b = 1'h0;
   logic [4:0] reg_addr = 5'h00;
   logic [15:0] reg_wdata = 16'h0000;
   logic reg_write = 1'h0;
   logic reg_read = 1'h0;
   logic cpu_idle = 1'h0;
   logic fault_input_a = 1'h0;
   logic fault_input_b = 1'h0;
   logic run = 1'h0;
   wire [15:0] reg_rdata;
   wire occ_time_base_s base_a;
   wire occ_time_base_s base_b;
   wire [7:0] compare_output_pin;
   wire [7:0] compare_event_flag;
   int miscompares = 0;
   int compares = 0;
   localparam occ_row_s ROWS [0:10] = '{
      '{3'h0, 1'h1, 1'h0, 1'h0, 1'h0, 1'h0, 2'h0},
      '{3'h1, 1'h1, 1'h0, 1'h0, 1'h0, 1'h1, 2'h1},
      '{3'h2, 1'h1, 1'h0, 1'h0, 1'h1, 1'h0, 2'h1},
      '{3'h3, 1'h1, 1'h0, 1'h0, 1'h0, 1'h1, 2'h3},
      '{3'h4, 1'h1, 1'h0, 1'h0, 1'h0, 1'h0, 2'h1},
      '{3'h5, 1'h1, 1'h0, 1'h0, 1'h0, 1'h0, 2'h3},
      '{3'h6, 1'h1, 1'h0, 1'h0, 1'h0, 1'h1, 2'h0},
      '{3'h7, 1'h1, 1'h0, 1'h0, 1'h0, 1'h1, 2'h0},
      '{3'h1, 1'h0, 1'h0, 1'h0, 1'h0, 1'h0, 2'h0},
      '{3'h1, 1'h1, 1'h1, 1'h1, 1'h0, 1'h0, 2'h0},
      '{3'h1, 1'h1, 1'h0, 1'h1, 1'h0, 1'h1, 2'h1}};

   always #2.5 ref_clk = ~ref_clk;

   occ_timer_model #(.PERIOD(16'h000F)) u_base_a (.ref_clk(ref_clk), .rst_b(rst_b),
      .run(run), .tb_out(base_a));
   occ_timer_model #(.PERIOD(16'h0013)) u_base_b (.ref_clk(ref_clk), .rst_b(rst_b),
      .run(run), .tb_out(base_b));
   occ_top u_dut (.ref_clk(ref_clk), .rst_b(rst_b), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
      .reg_rdata(reg_rdata), .time_base_first(base_a), .time_base_second(base_b),
      .cpu_idle(cpu_idle), .fault_input_a(fault_input_a), .fault_input_b(fault_input_b),
      .compare_output_pin(compare_output_pin), .compare_event_flag(compare_event_flag));

   // ****************************************************************
   // Bus tasks
   // ****************************************************************
   task automatic wr(input logic [4:0] a, input logic [15:0] d);
      reg_addr <= a;
      reg_wdata <= d;
      reg_write <= 1'h1;
      @(posedge ref_clk);
      reg_write <= 1'h0;
      @(posedge ref_clk);
   endtask

   task automatic chk_rd(input logic [4:0] a, input logic [15:0] exp);
      logic [15:0] d;
      reg_addr <= a;
      reg_read <= 1'h1;
      @(posedge ref_clk);
      reg_read <= 1'h0;
      #1 d = reg_rdata;
      `OCC_CHK("read data", exp, d)
      @(posedge ref_clk);
   endtask

   task automatic wrap_up;
      $display("Comparisons %0d, mismatches %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   // Every row restarts the base from zero so match cycles are known
   task automatic run_row(input occ_row_s r);
      int n;
      n = 0;
      wr(5'h00, 16'h0000);
      // PWM rows move the secondary value into the primary; restore it
      wr(5'h01, 16'h0010);
      wr(5'h00, {2'h0, r.sidl, 8'h00, 1'h0, r.tsel, r.mode});
      cpu_idle <= r.idle;
      repeat (3) @(posedge ref_clk);
      #1 `OCC_CHK("entry pin", r.entry, compare_output_pin[0])
      @(posedge ref_clk);
      run <= 1'h1;
      for (int i = 0; i < 70; i++) begin
         @(posedge ref_clk);
         #1 n += int'(compare_event_flag[0] !== 1'h0);
      end
      `OCC_CHK("final pin", r.final_pin, compare_output_pin[0])
      `OCC_CHK("events", int'(r.flags), n)
      @(posedge ref_clk);
      run <= 1'h0;
      cpu_idle <= 1'h0;
   endtask

   // ****************************************************************
   // Sequence
   // ****************************************************************
   initial begin
      repeat (20000) @(posedge ref_clk);
      miscompares++;
      wrap_up();
   end

   initial begin
      repeat (5) @(posedge ref_clk);
      rst_b <= 1'h1;
      @(posedge ref_clk);
      chk_rd(5'h00, 16'h0000);
      wr(5'h01, 16'h0010);
      wr(5'h02, 16'h0012);
      for (int i = 0; i < 11; i++) begin
         run_row(ROWS[i]);
         $display("Row %0d done", i);
      end
      wr(5'h1C, 16'hFFFF);
      chk_rd(5'h1C, 16'h200F);
      wr(5'h1C, 16'h0000);
      wr(5'h19, 16'hA5C3);
      chk_rd(5'h19, 16'hA5C3);
      wr(5'h0B, 16'hFFFF);
      chk_rd(5'h0B, 16'h0000);
      wr(5'h08, 16'h0010);
      chk_rd(5'h08, 16'h0000);
      $display("Register test done");
      // Channel 0 sits on fault A, channel 4 on fault B; both on the second
      // base, so the unfaulted one rises at its period rollover
      wr(5'h12, 16'h0012);
      for (int k = 0; k < 2; k++) begin
         wr(5'h00, 16'h000F);
         wr(5'h10, 16'h000F);
         run <= 1'h1;
         fault_input_a <= k == 0;
         fault_input_b <= k == 1;
         repeat (24) @(posedge ref_clk);
         #1 `OCC_CHK("fault pin", 1'h0, compare_output_pin[4 * k])
         `OCC_CHK("free pin", 1'h1, compare_output_pin[4 - 4 * k])
         @(posedge ref_clk);
         chk_rd(5'h00, k == 0 ? 16'h001F : 16'h000F);
         chk_rd(5'h10, k == 1 ? 16'h001F : 16'h000F);
         fault_input_a <= 1'h0;
         fault_input_b <= 1'h0;
         run <= 1'h0;
         wr(5'h00, 16'h0000);
         wr(5'h10, 16'h0000);
      end
      $display("Fault test done");
      wr(5'h00, 16'h0002);
      repeat (3) @(posedge ref_clk);
      rst_b <= 1'h0;
      @(posedge ref_clk);
      #1 `OCC_CHK("reset pin", 1'h0, compare_output_pin[0])
      @(posedge ref_clk);
      rst_b <= 1'h1;
      @(posedge ref_clk);
      chk_rd(5'h00, 16'h0000);
      $display("Reset test done");
      wrap_up();
   end
endmodule

`default_nettype wire
